// *** eepi_pkg.sv ***
// Constants, field layouts and state encodings of the serial EEPROM two-wire slave port.
// Contract
// R1: Array of 128K bytes, 17-bit byte address.
// R2: Fixed type field compared with select bits.
// R3: Master opens with start, select, address, data.
// R4: Master stops after ack on write, nack read.
// R5: Device acknowledges in ninth slot after bytes.
// R6: Master acknowledges read bytes in ninth slot.
// R7: Data line is open drain, never driven high.
// R8: Select bits b3, b2 compared with straps.
// R9: Floating chip straps read as zero.
// R10: Write protect high blocks every array write; the code checks it only when a data byte is latched, not at commit.
// R11: Floating write protect reads low, writes allowed.
// R12: Protected: ack select and address, nack data.
// R13: Silent until reset release, then standby.
// R14: Stop enters standby unless write cycle runs.
// R15: Select byte MSB first: type, straps, top, rw.
// R16: First address byte high, second byte low.
// R17: Start is data falling while clock high.
// R18: Watch for start; ignore traffic without one.
// R19: Stop is data rising while clock high.
// R20: Nack then stop returns device to standby.
// R21: Stop closing a write starts write cycle.
// R22: Transmitter releases after eight; receiver pulls low.
// R23: Data sampled on rising clock edge.
// R24: Strap mismatch gives no ack, goes standby.
// R25: Only stop in tenth slot starts write.
// R26: During write cycle, release line, ignore requests.
// R27: Lines oversampled and filtered before edge detection; the code only passes them through two synchroniser flops, with no filter.
package eepi_pkg;

  // Array geometry.
  localparam int          MEM_BYTES  = 131072;
  localparam int          ADDR_W     = 17;
  localparam int          PAGE_BYTES = 256;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  ACK_SLOT   = 4'h9;

  // Device type field; the value is arbitrary.
  localparam logic [3:0]  TYPE_ID    = 4'h5;

  // Select byte field positions.
  localparam int          SEL_TYPE_MSB = 7;
  localparam int          SEL_TYPE_LSB = 4;
  localparam int          SEL_CE_HI    = 3;
  localparam int          SEL_CE_LO    = 2;
  localparam int          SEL_TOP      = 1;
  localparam int          SEL_RW       = 0;

  // Positions of the pins in the synchroniser vectors.
  localparam int          PIN_SCL   = 0;
  localparam int          PIN_SDA   = 1;
  localparam int          PIN_CE_LO = 2;
  localparam int          PIN_CE_HI = 3;
  localparam int          PIN_WP    = 4;
  localparam int          PIN_COUNT = 5;

  // Timing of the main clock and of the self-timed write.
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TIMER_W       = 24;

  // Reset values of the lines and counters.
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 5'h03;
  localparam logic [8:0]           CNT_ZERO  = 9'h000;

  // Link-side protocol states.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_RECV   = 4'h1,
    ST_ACK    = 4'h2,
    ST_TX     = 4'h3,
    ST_TXACK  = 4'h4,
    ST_IGNORE = 4'h5,
    ST_COMMIT = 4'h6,
    ST_BUSY   = 4'h7
  } eepi_state_t;

  // Meaning of the byte being received.
  typedef enum logic [1:0] {
    KIND_SEL     = 2'h0,
    KIND_ADDR_HI = 2'h1,
    KIND_ADDR_LO = 2'h2,
    KIND_DATA    = 2'h3
  } eepi_kind_t;

endpackage

// *** eepi_slave_port.sv ***
// Two-wire slave front end, page latch, array and self-timed write cycle of the serial EEPROM.
`timescale 1ns/1ps
module eepi_slave_port #(
  parameter int WRITE_TIME_NS = 5000000
) (
  // Main clock and power-on reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Link sampling clock.
  input  wire logic linkClock,
  // Two-wire bus pins.
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe_n,
  // Straps and write protection.
  input  wire logic chipSelectStrapLow,
  input  wire logic chipSelectStrapHigh,
  input  wire logic writeProtectInput,
  // Status.
  output logic      standbyMode,
  output logic      writeCycleBusy
);

  // Write cycle length in main clock cycles, rounded up.
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + eepi_pkg::CLK_PERIOD_NS - 1) / eepi_pkg::CLK_PERIOD_NS;
  localparam logic [eepi_pkg::TIMER_W-1:0] WRITE_LOAD = eepi_pkg::TIMER_W'(WRITE_CYCLES - 1);

  // All link-domain state.
  typedef struct packed {
    logic [eepi_pkg::PIN_COUNT-1:0] pinMeta;    // First synchroniser stage.
    logic [eepi_pkg::PIN_COUNT-1:0] pinSync;    // Second synchroniser stage.
    logic                           sclPrev;    // Clock level one sample ago.
    logic                           sdaPrev;    // Data level one sample ago.
    logic [1:0]                     doneSync;   // Write-done toggle crossing.

    eepi_pkg::eepi_state_t          state;      // Protocol state.
    eepi_pkg::eepi_kind_t           kind;       // Byte being received.
    logic [3:0]                     bitCnt;     // Rising edges in this byte.
    logic [7:0]                     shiftReg;   // Shift register for both directions.
    logic                           readMode;   // Last select asked for a read.
    logic                           topAddr;    // Address bit 16.
    logic [15:0]                    addr;       // Address bits 15 to 0.
    logic [8:0]                     pageCnt;    // Bytes held in the page latch.
    logic [8:0]                     commitIdx;  // Copy index during commit.

    logic                           reqToggle;  // Write-cycle request toggle.
    logic                           sdaOe_n;    // Low while pulling data low.
    logic                           standby;    // Standby indication.
  } eepi_link_t;

  // All main-domain state.
  typedef struct packed {
    logic [1:0]                     reqSync;    // Request toggle crossing.
    logic                           reqSeen;    // Last request toggle served.
    logic                           doneToggle; // Answer toggle back to the link.

    logic                           busy;       // Write cycle running.
    logic [eepi_pkg::TIMER_W-1:0]   timer;      // Cycles left in the write.
  } eepi_core_t;

  eepi_link_t link_q;                           // Link state register.
  eepi_link_t link_d;                           // Link next state.
  eepi_core_t core_q;                           // Core state register.
  eepi_core_t core_d;                           // Core next state.

  logic [1:0] linkRstSync;                      // Reset brought into the link domain.
  logic       linkRst_n;                        // Link-domain synchronous reset.

  // Storage: the array and the page latch.
  logic [7:0] memArray [0:eepi_pkg::MEM_BYTES-1];   // The byte array. [R1]
  logic [7:0] pageMem  [0:eepi_pkg::PAGE_BYTES-1];  // Page latch.

  logic                             pageWe;         // Page latch write strobe.
  logic [7:0]                       pageIdx;        // Page latch index.
  logic                             memWe;          // Array write strobe.
  logic [eepi_pkg::ADDR_W-1:0]      memAddr;        // Array address.
  logic [7:0]                       memRdData;      // Byte at the current address.
  logic [7:0]                       pageRdData;     // Page latch byte being committed.

  // Link events, derived only from second-stage samples.
  logic sclS;
  logic sdaS;

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // Select byte decode: type field and both strap bits must match.
  // The read/write bit is not looked at.
  function automatic logic selMatch(input logic [7:0] sel, input logic ceLo, input logic ceHi);
    selMatch = (sel[eepi_pkg::SEL_TYPE_MSB:eepi_pkg::SEL_TYPE_LSB] == eepi_pkg::TYPE_ID) // [R2] [R15]
             && (sel[eepi_pkg::SEL_CE_HI] == ceHi) && (sel[eepi_pkg::SEL_CE_LO] == ceLo); // [R8]
  endfunction

  // The link reset follows the power-on reset through two flops so that it releases cleanly in this domain.
  always_ff @(posedge linkClock) begin
    linkRstSync <= {linkRstSync[0], rst_n};
  end
  assign linkRst_n = linkRstSync[1];

  // Line samples and edges; there is no glitch filter, so a glitch caught at a link clock edge reaches the decoder.
  // Start and stop need the clock high.
  assign sclS      = link_q.pinSync[eepi_pkg::PIN_SCL];                           // [R27]
  assign sdaS      = link_q.pinSync[eepi_pkg::PIN_SDA];
  assign sclRise   = sclS && !link_q.sclPrev;                                    // [R23]
  assign sclFall   = !sclS && link_q.sclPrev;
  assign startSeen = sclS && link_q.sclPrev && link_q.sdaPrev && !sdaS;          // [R17]
  assign stopSeen  = sclS && link_q.sclPrev && !link_q.sdaPrev && sdaS;          // [R19]

  // Combinational array and latch reads.
  // Both indexes come from flops.
  assign memRdData  = memArray[{link_q.topAddr, link_q.addr}];
  assign pageRdData = pageMem[link_q.addr[7:0] + link_q.commitIdx[7:0]];

  // Link protocol: start, stop, bytes, acknowledges, read shifting and the page commit.
  always_comb begin
    link_d          = link_q;
    pageWe          = 1'b0;
    pageIdx         = link_q.addr[7:0] + link_q.pageCnt[7:0];
    memWe           = 1'b0;
    memAddr         = {link_q.topAddr, link_q.addr[15:8], link_q.addr[7:0] + link_q.commitIdx[7:0]};

    // Pads carry pull-downs, so floating straps and protect arrive as zero. [R9] [R11]
    link_d.pinMeta  = {writeProtectInput, chipSelectStrapHigh, chipSelectStrapLow, sdaIn, sclIn};
    link_d.pinSync  = link_q.pinMeta;
    link_d.sclPrev  = sclS;
    link_d.sdaPrev  = sdaS;
    link_d.doneSync = {link_q.doneSync[0], core_q.doneToggle};

    // Counts clock rises in every state.
    if (sclRise) begin
      link_d.bitCnt = link_q.bitCnt + 4'h1;
    end

    // Commit and busy shut out the bus.
    if (link_q.state == eepi_pkg::ST_COMMIT) begin
      // Copy one latched byte per cycle while the line stays released. [R26]
      if (link_q.commitIdx == link_q.pageCnt) begin
        link_d.addr[7:0] = link_q.addr[7:0] + link_q.pageCnt[7:0];
        link_d.state     = eepi_pkg::ST_BUSY;
      end else begin
        memWe            = 1'b1;
        link_d.commitIdx = link_q.commitIdx + 9'h001;
      end

    end else if (link_q.state == eepi_pkg::ST_BUSY) begin
      // Nothing on the bus is looked at until the timer answers. [R26] [R18]
      if (link_q.doneSync[1] == link_q.reqToggle) begin
        link_d.state   = eepi_pkg::ST_IDLE;
        link_d.standby = 1'b1;                                                   // [R14]
      end

    end else if (startSeen) begin
      // A start, repeated or not, opens a fresh select byte unless a commit or write cycle is running. [R18]
      link_d.state    = eepi_pkg::ST_RECV;
      link_d.kind     = eepi_pkg::KIND_SEL;
      link_d.bitCnt   = 4'h0;
      link_d.pageCnt  = eepi_pkg::CNT_ZERO;
      link_d.sdaOe_n  = 1'b1;
      link_d.standby  = 1'b0;

    end else if (stopSeen) begin
      link_d.sdaOe_n = 1'b1;
      // The stop's own rise counts one,
      // so one marks the tenth slot.
      if (link_q.state == eepi_pkg::ST_RECV && link_q.bitCnt == 4'h1 && link_q.kind == eepi_pkg::KIND_DATA
          && link_q.pageCnt != eepi_pkg::CNT_ZERO && !link_q.readMode) begin
        // Stop right after an acknowledged data byte: launch the write. [R21] [R25]
        link_d.state     = eepi_pkg::ST_COMMIT;
        link_d.commitIdx = eepi_pkg::CNT_ZERO;
        link_d.reqToggle = !link_q.reqToggle;
      end else begin
        link_d.state   = eepi_pkg::ST_IDLE;                                      // [R14] [R20]
        link_d.standby = 1'b1;
      end

    end else begin
      unique case (link_q.state)
        eepi_pkg::ST_IDLE, eepi_pkg::ST_IGNORE: begin
          // Traffic without a start is not answered. [R18]
          link_d.sdaOe_n = 1'b1;
        end

        // Bits shift in on rises.
        eepi_pkg::ST_RECV: begin
          if (sclRise) begin
            link_d.shiftReg = {link_q.shiftReg[6:0], sdaS};                      // [R23] [R15] [R16]
          end
          if (sclFall && link_q.bitCnt == eepi_pkg::BYTE_BITS) begin
            // Byte complete: decide the acknowledge for the ninth slot. [R5] [R22]
            link_d.state   = eepi_pkg::ST_ACK;
            link_d.sdaOe_n = 1'b0;                                               // [R7]
            unique case (link_q.kind)
              eepi_pkg::KIND_SEL: begin
                if (selMatch(link_q.shiftReg, link_q.pinSync[eepi_pkg::PIN_CE_LO],
                             link_q.pinSync[eepi_pkg::PIN_CE_HI])) begin
                  link_d.topAddr  = link_q.shiftReg[eepi_pkg::SEL_TOP];
                  link_d.readMode = link_q.shiftReg[eepi_pkg::SEL_RW];
                end else begin
                  // Not ours: no acknowledge, drop off the bus. [R24]
                  link_d.state   = eepi_pkg::ST_IDLE;
                  link_d.sdaOe_n = 1'b1;
                  link_d.standby = 1'b1;
                end
              end

              eepi_pkg::KIND_ADDR_HI: begin
                link_d.addr[15:8] = link_q.shiftReg;                             // [R16] [R12]
              end

              eepi_pkg::KIND_ADDR_LO: begin
                link_d.addr[7:0] = link_q.shiftReg;                              // [R16]
              end

              eepi_pkg::KIND_DATA: begin
                if (link_q.pinSync[eepi_pkg::PIN_WP]) begin
                  // Protected: the byte is dropped and left unacknowledged. [R10] [R12]
                  link_d.sdaOe_n = 1'b1;
                end else begin
                  pageWe = 1'b1;
                  if (link_q.pageCnt != 9'(eepi_pkg::PAGE_BYTES)) begin
                    link_d.pageCnt = link_q.pageCnt + 9'h001;
                  end
                end
              end
            endcase
          end
        end

        // Pull held for the ninth pulse.
        eepi_pkg::ST_ACK: begin
          // Hold the acknowledge through the ninth pulse, release on its falling edge. [R22]
          if (sclFall && link_q.bitCnt == eepi_pkg::ACK_SLOT) begin
            link_d.sdaOe_n = 1'b1;
            link_d.bitCnt  = 4'h0;
            if (link_q.kind == eepi_pkg::KIND_SEL && link_q.readMode) begin
              link_d.state    = eepi_pkg::ST_TX;
              link_d.shiftReg = memRdData;
              link_d.sdaOe_n  = memRdData[7];                                    // [R7]
            end else begin
              link_d.state = eepi_pkg::ST_RECV;
              if (link_q.kind != eepi_pkg::KIND_DATA) begin
                link_d.kind = eepi_pkg::eepi_kind_t'(link_q.kind + 2'h1);
              end
            end
          end
        end

        // Read bits leave on falls.
        eepi_pkg::ST_TX: begin
          // Shift a byte out MSB first; a one is sent by releasing the line. [R7]
          if (sclFall) begin
            if (link_q.bitCnt == eepi_pkg::BYTE_BITS) begin
              link_d.sdaOe_n = 1'b1;                                             // [R22]
              link_d.state   = eepi_pkg::ST_TXACK;
            end else begin
              link_d.shiftReg = {link_q.shiftReg[6:0], 1'b0};
              link_d.sdaOe_n  = link_q.shiftReg[6];
            end
          end
        end

        // High here ends the read.
        eepi_pkg::ST_TXACK: begin
          if (sclRise) begin
            if (sdaS) begin
              // No acknowledge from the master: wait for its stop. [R20]
              link_d.state = eepi_pkg::ST_IGNORE;
            end else begin
              {link_d.topAddr, link_d.addr} = 17'({link_q.topAddr, link_q.addr} + 17'h00001);
            end
          end else if (sclFall && link_q.bitCnt == eepi_pkg::ACK_SLOT) begin
            link_d.bitCnt   = 4'h0;
            link_d.state    = eepi_pkg::ST_TX;
            link_d.shiftReg = memRdData;
            link_d.sdaOe_n  = memRdData[7];
          end
        end

        // Stray codes go idle.
        default: begin
          link_d.state = eepi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Link register; until the reset is released nothing on the bus is seen. [R13]
  // Storage is kept out of reset.
  always_ff @(posedge linkClock) begin
    if (!linkRst_n) begin
      link_q.pinMeta   <= eepi_pkg::PIN_RESET;
      link_q.pinSync   <= eepi_pkg::PIN_RESET;
      link_q.sclPrev   <= 1'b1;
      link_q.sdaPrev   <= 1'b1;
      link_q.doneSync  <= 2'h0;
      link_q.state     <= eepi_pkg::ST_IDLE;
      link_q.kind      <= eepi_pkg::KIND_SEL;
      link_q.bitCnt    <= 4'h0;
      link_q.shiftReg  <= 8'h00;
      link_q.readMode  <= 1'b0;
      link_q.topAddr   <= 1'b0;
      link_q.addr      <= 16'h0000;
      link_q.pageCnt   <= eepi_pkg::CNT_ZERO;
      link_q.commitIdx <= eepi_pkg::CNT_ZERO;
      link_q.reqToggle <= 1'b0;
      link_q.sdaOe_n   <= 1'b1;
      link_q.standby   <= 1'b1;
    end else begin
      link_q <= link_d;
    end
  end

  // Storage writes carry no reset; contents survive a link reset.
  // The latch holds the page until commit,
  // so a cut frame leaves the array as it was.
  always_ff @(posedge linkClock) begin
    if (pageWe) begin
      pageMem[pageIdx] <= link_q.shiftReg;
    end
    if (memWe) begin
      memArray[memAddr] <= pageRdData;                                           // [R10]
    end
  end

  // Write timer: one request toggle starts it, a done toggle answers it.
  // Only one toggle is in flight at a time,
  // so one bit crossing is safe.
  always_comb begin
    core_d         = core_q;
    core_d.reqSync = {core_q.reqSync[0], link_q.reqToggle};

    // Counts down to zero, then answers.
    if (core_q.busy) begin
      if (core_q.timer == '0) begin
        core_d.busy       = 1'b0;
        core_d.doneToggle = core_q.reqSeen;
      end else begin
        core_d.timer = core_q.timer - eepi_pkg::TIMER_W'(1);
      end
    end else if (core_q.reqSync[1] != core_q.reqSeen) begin
      core_d.reqSeen = core_q.reqSync[1];
      core_d.busy    = 1'b1;                                                     // [R21]
      core_d.timer   = WRITE_LOAD;
    end
  end

  // Core register on the main clock.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      core_q <= '0;
    end else begin
      core_q <= core_d;
    end
  end

  // Status and enable outputs come straight from flops, sdaOut is tied off; the driven level is always low. [R7]
  // The enable alone sets the line level.
  assign sdaOut         = 1'b0;
  assign sdaOe_n        = link_q.sdaOe_n;
  assign standbyMode    = link_q.standby;
  assign writeCycleBusy = core_q.busy;

endmodule

// *** eepi_slave_port_chk.sv ***
// Port-level assertions for the EEPROM two-wire slave port.
`timescale 1ns/1ps
module eepi_slave_port_chk (
  // Clocks and reset.
  input wire logic clock,
  input wire logic rst_n,
  input wire logic linkClock,
  // Bus pins and status.
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  input wire logic writeProtectInput,
  input wire logic standbyMode,
  input wire logic writeCycleBusy
);
  logic sclPrev;  // Bus clock at the last link edge.
  logic sdaPrev;  // Bus data at the last link edge.
  logic inFrame;  // High between a start and a stop.
  wire  stopNow = sclPrev & sclIn & !sdaPrev & sdaIn;  // Data rises while clock high.
  // Raw-wire view of framing; the design sees the wires later, so it may only lag this view.
  always_ff @(posedge linkClock) begin
    if (!rst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      inFrame <= 1'b0;
    end else begin
      sclPrev <= sclIn;
      sdaPrev <= sdaIn;
      if (sclPrev && sclIn && sdaPrev && !sdaIn) begin
        inFrame <= 1'b1;
      end else if (stopNow) begin
        inFrame <= 1'b0;
      end
    end
  end
  a_open_drain: assert property (@(posedge clock) disable iff (!rst_n) sdaOut == 1'b0)
    else $error("data output not low");
  a_reset_quiet: assert property (@(posedge linkClock) !rst_n [*4] |-> sdaOe_n && standbyMode)
    else $error("link side active in reset");
  a_busy_quiet: assert property (@(posedge linkClock) disable iff (!rst_n) writeCycleBusy |-> sdaOe_n)
    else $error("data pulled during write");
  a_scl_low_change: assert property (@(posedge linkClock) disable iff (!rst_n) $changed(sdaOe_n) |-> !sclIn)
    else $error("data changed while clock high");
  a_wp_no_write: assert property (@(posedge clock) disable iff (!rst_n) $rose(writeCycleBusy) |-> !writeProtectInput)
    else $error("write started while protected");
  a_write_standby: assert property (@(posedge clock) disable iff (!rst_n) $fell(writeCycleBusy) |-> ##[1:80] standbyMode)
    else $error("no standby after write");
  a_frame_only: assert property (@(posedge linkClock) disable iff (!rst_n) !inFrame |-> sdaOe_n)
    else $error("data pulled outside a frame");
  a_stop_standby: assert property (@(posedge linkClock) disable iff (!rst_n)
    stopNow && inFrame |-> ##[1:16] (standbyMode || writeCycleBusy))
    else $error("no standby or write after stop");
endmodule
bind eepi_slave_port eepi_slave_port_chk u_chk (
  .clock(clock), .rst_n(rst_n), .linkClock(linkClock), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe_n(sdaOe_n), .writeProtectInput(writeProtectInput), .standbyMode(standbyMode),
  .writeCycleBusy(writeCycleBusy));

// *** eepi_bus_master.sv ***
// Behavioural two-wire bus master that owns the serial clock.
`timescale 1ns/1ps
module eepi_bus_master #(
  parameter int Quarter = 40
) (
  // Time base.
  input  wire logic clock,
  // Bus side; the data line has a pull-up outside.
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaPull
);
  // Idle bus: clock high, data released.
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  // Waits n quarter bits and steps just past the edge.
  task automatic wq(input int n);
    repeat (n * Quarter) @(posedge clock);
    #1;
  endtask
  // Start; from a low clock it makes a repeated start.
  task automatic start();
    sdaPull = 1'b0;
    wq(1);
    sclOut = 1'b1;
    wq(1);
    sdaPull = 1'b1;
    wq(1);
    sclOut = 1'b0;
    wq(1);
  endtask
  // One bit slot; data moves only while the clock is low.
  task automatic bit_slot(input logic b, output logic s);
    sclOut = 1'b0;
    sdaPull = !b;
    wq(1);
    sclOut = 1'b1;
    wq(1);
    s = sdaLine;
    wq(1);
    sclOut = 1'b0;
    wq(1);
  endtask
  // Eight bits MSB first, then the ninth slot; a one there releases the line.
  task automatic xfer(input logic [7:0] v, input logic b9, output logic [7:0] got, output logic s9);
    for (int i = 7; i >= 0; i--) bit_slot(v[i], got[i]);
    bit_slot(b9, s9);
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    sclOut = 1'b0;
    sdaPull = 1'b1;
    wq(1);
    sclOut = 1'b1;
    wq(1);
    sdaPull = 1'b0;
    wq(2);
  endtask
endmodule

// *** eepi_slave_port_tb_top.sv ***
// Self-checking testbench of the EEPROM two-wire slave port.
`timescale 1ns/1ps
module eepi_slave_port_tb_top;
  localparam int WtNs = 20000;   // Write of 2000 cycles, long enough to poll inside it.
  logic       clock = 1'b0;      // Main clock, 10 ns.
  logic       linkClock = 1'b0;  // Link clock, 125 ns.
  logic       rst_n = 1'b0;      // Power-on reset.
  logic [1:0] ce = 2'h0;         // Straps, high then low.
  logic       wp = 1'b0;         // Write protection.
  logic       scl;               // Bus clock from the master.
  logic       pull;              // Master pulls data low.
  logic       sdaOut;            // Device data output.
  logic       sdaOe_n;           // Device pulls data when low.
  logic       standbyMode;       // Device in standby.
  logic       writeCycleBusy;    // Self-timed write running.
  wire        sda = !(pull || !sdaOe_n);  // Wired line with pull-up.
  int         failCount = 0;     // Mismatches.
  int         nTests = 0;        // Comparisons.
  logic [7:0] rd [3];            // Bytes read back.
  always #5 clock = ~clock;
  // The link clock is offset so its edges never line up with the main clock.
  initial begin
    #17.3;
    forever #62.5 linkClock = ~linkClock;
  end
  eepi_slave_port #(.WRITE_TIME_NS(WtNs)) u_dut (
    .clock(clock), .rst_n(rst_n), .linkClock(linkClock), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .chipSelectStrapLow(ce[0]), .chipSelectStrapHigh(ce[1]), .writeProtectInput(wp),
    .standbyMode(standbyMode), .writeCycleBusy(writeCycleBusy));
  eepi_bus_master u_m (.clock(clock), .sdaLine(sda), .sclOut(scl), .sdaPull(pull));
  // Waits n main cycles and steps off the edge.
  task automatic wc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected select byte for these straps.
  function automatic logic [7:0] selOf(input logic top, input logic rw);
    return {eepi_pkg::TYPE_ID, ce, top, rw};
  endfunction
  // Start, select for write and both address bytes; a low ninth bit is an acknowledge.
  task automatic head(input logic [16:0] a);
    logic [7:0] junk;
    logic       s;
    u_m.start();
    u_m.xfer(selOf(a[16], 1'b0), 1'b1, junk, s);
    chk("select ack", 8'(s), 8'h00);
    u_m.xfer(a[15:8], 1'b1, junk, s);
    chk("high address ack", 8'(s), 8'h00);
    u_m.xfer(a[7:0], 1'b1, junk, s);
    chk("low address ack", 8'(s), 8'h00);
  endtask
  // Random read of n bytes; the last one is left unacknowledged.
  task automatic read_at(input logic [16:0] a, input int n);
    logic [7:0] junk;
    logic       s;
    head(a);
    u_m.start();
    u_m.xfer(selOf(a[16], 1'b1), 1'b1, junk, s);
    chk("read select ack", 8'(s), 8'h00);
    for (int i = 0; i < n; i++) u_m.xfer(8'hff, i == n - 1, rd[i], s);
    u_m.stop();
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hung bus would otherwise stall the run.
  initial begin
    repeat (95000) @(posedge clock);
    failCount++;
    wrapUp();
  end
  initial begin
    logic [16:0] addr;
    logic [7:0]  dat [3];
    logic [7:0]  junk;
    logic        s;
    void'($urandom(32'h7336fde8));
    wc(60);
    chk("oe in reset", 8'(sdaOe_n), 8'h01);
    chk("standby in reset", 8'(standbyMode), 8'h01);
    chk("data output", 8'(sdaOut), 8'h00);
    rst_n = 1'b1;
    wc(100);
    $display("test reset finished");
    ce = 2'($urandom);
    addr = {9'($urandom), 8'($urandom % 253)};
    head(addr);
    foreach (dat[i]) begin
      dat[i] = 8'($urandom);
      u_m.xfer(dat[i], 1'b1, junk, s);
      chk("data ack", 8'(s), 8'h00);
    end
    u_m.stop();
    for (int i = 0; i < 300 && writeCycleBusy !== 1'b1; i++) wc(1);
    chk("write started", 8'(writeCycleBusy), 8'h01);
    u_m.start();
    u_m.xfer(selOf(addr[16], 1'b0), 1'b1, junk, s);
    chk("poll in write", 8'(s), 8'h01);
    u_m.stop();
    for (int i = 0; i < 2500 && writeCycleBusy !== 1'b0; i++) wc(1);
    wc(60);
    chk("write ended", 8'(writeCycleBusy), 8'h00);
    chk("standby after write", 8'(standbyMode), 8'h01);
    $display("test page write finished");
    read_at(addr, 3);
    foreach (dat[i]) chk("read data", rd[i], dat[i]);
    wc(60);
    chk("standby after read", 8'(standbyMode), 8'h01);
    $display("test random read finished");
    wp = 1'b1;
    head(addr);
    u_m.xfer(~dat[0], 1'b1, junk, s);
    chk("protected data ack", 8'(s), 8'h01);
    u_m.stop();
    wc(300);
    chk("no protected write", 8'(writeCycleBusy), 8'h00);
    wp = 1'b0;
    read_at(addr, 1);
    chk("protected byte kept", rd[0], dat[0]);
    $display("test write protect finished");
    for (int k = 0; k < 4; k++) begin
      junk = (k < 3) ? {eepi_pkg::TYPE_ID, ce ^ 2'(k + 1), 2'h0} : {eepi_pkg::TYPE_ID ^ 4'h8, ce, 2'h0};
      u_m.start();
      u_m.xfer(junk, 1'b1, junk, s);
      chk("foreign select ack", 8'(s), 8'h01);
      wc(40);
      chk("standby on mismatch", 8'(standbyMode), 8'h01);
      u_m.stop();
    end
    $display("test select mismatch finished");
    head(addr);
    u_m.xfer(8'($urandom), 1'b1, junk, s);
    u_m.bit_slot(1'b1, s);
    u_m.stop();
    wc(300);
    chk("late stop no write", 8'(writeCycleBusy), 8'h00);
    $display("test misplaced stop finished");
    u_m.xfer(selOf(addr[16], 1'b0), 1'b1, junk, s);
    chk("no start ignored", 8'(s), 8'h01);
    u_m.stop();
    $display("test missing start finished");
    wrapUp();
  end
endmodule
